// ### bench/mii_phy_model.sv
/*
 Receive side of an MII PHY: sends one frame per call, low nibble first.
 Assumes the receiver samples on the rising edge of mii_rx_clk.
*/
`timescale 1ns/100ps
module mii_phy_model (
   // MII receive pins
   output logic mii_rx_clk,
   output logic mii_rx_dv,
   output logic mii_rx_er,
   output logic [3:0] mii_rxd,
   output logic mii_col
);
   initial begin
      mii_rx_clk = 1'b0;
      mii_rx_dv = 1'b0;
      mii_rx_er = 1'b0;
      mii_rxd = 4'hA;
      mii_col = 1'b0;
   end
   task automatic put(input logic [3:0] nib, input logic er, input logic col);
      mii_rxd = nib;
      mii_rx_er = er;
      mii_col = col;
      #200 mii_rx_clk = 1'b1;
      #200 mii_rx_clk = 1'b0;
   endtask
   // Clock runs through the frame and its gap only; idle data toggles so no stale value reads true
   task automatic send(input logic [7:0] q[$], input bit odd, input int er_at, input int col_at);
      #7;
      mii_rx_dv = 1'b1;
      repeat (7) put(rx_status_pkg::PRE_NIBBLE, 1'b0, 1'b0);
      put(rx_status_pkg::SFD_NIBBLE, 1'b0, 1'b0);
      foreach (q[i]) begin
         put(q[i][3:0], i == er_at, i >= col_at);
         put(q[i][7:4], 1'b0, i >= col_at);
      end
      if (odd) put(4'h3, 1'b0, 1'b0);
      mii_rx_dv = 1'b0;
      repeat (12) put(~mii_rxd, 1'b0, 1'b0);
   endtask
endmodule // mii_phy_model

// ### bench/rx_status_assertions.sv
/*
 Port checker for the receive status classifier.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module rx_status_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // MII and register port
   input wire logic mii_rx_dv,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic transfer_done_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic fd_reg, fd_next, fdf_reg, fdf_next, arm_reg, arm_next, done_d_reg;
   logic xfer_clr;
   assign xfer_clr = wr && addr == rx_status_pkg::OFF_RX_XFER && wdata[1];
   // Duplex is latched per frame so a later mode write cannot blame an old status
   always_comb begin
      fd_next = fd_reg;
      fdf_next = fdf_reg;
      arm_next = arm_reg;
      if (wr && addr == rx_status_pkg::OFF_MAC_CTRL) fd_next = wdata[0];
      if (wr && addr == rx_status_pkg::OFF_RX_XFER && wdata[0]) arm_next = 1'b1;
      if (transfer_done_flag && !done_d_reg) begin
         arm_next = 1'b0;
         fdf_next = fd_reg;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fd_reg <= 1'b0;
         fdf_reg <= 1'b0;
         arm_reg <= 1'b0;
         done_d_reg <= 1'b0;
      end else begin
         fd_reg <= fd_next;
         fdf_reg <= fdf_next;
         arm_reg <= arm_next;
         done_d_reg <= transfer_done_flag;
      end
   end
   sequence s_status_read;
      rd && addr == rx_status_pkg::OFF_RX_STATUS;
   endsequence
   sequence s_done_rise;
      $rose(transfer_done_flag);
   endsequence
   property p_rdata_idle;
      !rd |=> rdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
   property p_unsup_ctrl;
      s_status_read |=> !(rdata[26] && !rdata[25]);
   endproperty
   a_unsup_ctrl: assert property (p_unsup_ctrl) else $error("unsupported flag without control");
   property p_len_type;
      s_status_read |=> !(rdata[24] && rdata[18]);
   endproperty
   a_len_type: assert property (p_len_type) else $error("length error on typed frame");
   property p_half_duplex;
      (rd && addr == rx_status_pkg::OFF_RX_STATUS && !fdf_reg) |=> rdata[26:25] == 2'b00;
   endproperty
   a_half_duplex: assert property (p_half_duplex) else $error("control flags in half duplex");
   property p_done_idle_line;
      // Done may not rise in the cycle right after one with the line still valid
      mii_rx_dv |=> !$rose(transfer_done_flag);
   endproperty
   a_done_idle_line: assert property (p_done_idle_line) else $error("done during a frame");
   property p_done_armed;
      s_done_rise |-> arm_reg;
   endproperty
   a_done_armed: assert property (p_done_armed) else $error("done without enable");
   property p_done_hold;
      transfer_done_flag && !xfer_clr && !$past(xfer_clr) |=> transfer_done_flag;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done dropped without clear");
   property p_reset_quiet;
      $rose(resetn) |-> (rdata == 32'h0 && !transfer_done_flag) [*2];
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule // rx_status_checker

bind rx_frame_status_classifier rx_status_checker u_rx_status_checker (.mclk(mclk), .resetn(resetn),
   .mii_rx_dv(mii_rx_dv), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .transfer_done_flag(transfer_done_flag));

// ### bench/testbench.sv
/*
 Self-checking bench for the receive status classifier with an MII sender.
 Assumes the checker is bound in and reads answer one cycle after the strobe.
*/
`timescale 1ns/100ps
module testbench;
   logic mclk, resetn, wr, rd, mii_rx_clk, mii_rx_dv, mii_rx_er, mii_col, transfer_done_flag;
   logic [3:0] mii_rxd;
   logic [7:0] addr;
   logic [7:0] fq[$];
   logic [31:0] wdata, rdata, rd_val, last_exp;
   int n_mismatch, total_checks, cycles, fd, vt1, vt2;

   rx_frame_status_classifier u_rx_frame_status_classifier (.mclk(mclk), .resetn(resetn),
      .mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd),
      .mii_col(mii_col), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .transfer_done_flag(transfer_done_flag));
   mii_phy_model u_mii_phy_model (.mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv),
      .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd), .mii_col(mii_col));

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 100000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask
   function automatic logic [31:0] crc32(input logic [7:0] q[$]);
      logic [31:0] c;
      c = 32'hFFFF_FFFF;
      foreach (q[i])
         for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ ((c[0] ^ q[i][b]) ? 32'hEDB8_8320 : 32'h0);
      return ~c;
   endfunction
   // Builds a frame, predicts its status word, sends it armed and clears done afterwards
   task automatic run(input string name, input int lt, plen, op, input bit odd, bad, input int er_at, col_at);
      logic [7:0] q[$];
      logic [31:0] fcs;
      logic [9:0] flags;
      int n, data, lim;
      bit ctl, ft, m1, m2, lng;
      repeat (12) q.push_back(8'($urandom));
      q.push_back(8'(lt >> 8));
      q.push_back(8'(lt));
      q.push_back(8'(op >> 8));
      q.push_back(8'(op));
      repeat (plen - 2) q.push_back(8'($urandom));
      fcs = crc32(q);
      if (bad) fcs = ~fcs;
      for (int k = 0; k < 4; k++) q.push_back(fcs[8*k +: 8]);
      n = q.size();
      data = n - 18;
      ctl = fd != 0 && lt == 16'h8808;
      ft = lt > 1500;
      m1 = lt != 0 && lt == vt1;
      m2 = lt != 0 && lt == vt2;
      lim = m2 ? 1538 : (m1 ? 1518 : 1500);
      lng = data > lim;
      flags = {ctl && (op != 1 || n != 64), ctl, !ft && !lng && data < lt, m2, m1, bad && !lng, odd,
         er_at >= 0, ft, col_at >= 64 && col_at < n};
      wr_reg(rx_status_pkg::OFF_RX_XFER, 32'h1);
      rd_reg(rx_status_pkg::OFF_RX_XFER, rd_val);
      check("armed", rd_val, 32'h1);
      u_mii_phy_model.send(q, odd, er_at, col_at);
      for (int k = 0; k < 400 && transfer_done_flag !== 1'b1; k++) @(posedge mclk);
      check("done", {31'h0, transfer_done_flag}, 32'h1);
      // Frame end drops the enable and leaves only done standing
      rd_reg(rx_status_pkg::OFF_RX_XFER, rd_val);
      check("xfer after frame", rd_val, 32'h2);
      rd_reg(rx_status_pkg::OFF_RX_STATUS, rd_val);
      last_exp = {5'h0, flags, 17'h0};
      check(name, rd_val, last_exp);
      wr_reg(rx_status_pkg::OFF_RX_XFER, 32'h2);
      repeat (3) @(posedge mclk);
      check("done clear", {31'h0, transfer_done_flag}, 32'h0);
      $display("test %s done", name);
   endtask

   initial begin
      resetn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      void'($urandom(39));
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      // A write to the read-only status word and one to an unmapped place must leave no trace
      wr_reg(rx_status_pkg::OFF_RX_STATUS, 32'hFFFF_FFFF);
      wr_reg(8'h14, 32'hFFFF_FFFF);
      for (int a = 0; a <= 20; a += 4) begin
         rd_reg(8'(a), rd_val);
         check("reset value", rd_val, 32'h0);
      end
      $display("test registers done");
      vt1 = 16'h0123;
      vt2 = 0;
      fd = 1;
      wr_reg(rx_status_pkg::OFF_VLAN1_TAG, 32'(vt1));
      wr_reg(rx_status_pkg::OFF_MAC_CTRL, 32'(fd));
      rd_reg(rx_status_pkg::OFF_VLAN1_TAG, rd_val);
      check("vlan1 tag", rd_val, 32'h0123);
      run("pause", 16'h8808, 46, 1, 0, 0, -1, 9999);
      run("bad opcode", 16'h8808, 46, 2, 0, 0, -1, 9999);
      run("ctl length", 16'h8808, 50, 1, 0, 0, -1, 9999);
      run("zero tag", 0, 46, 1, 0, 0, -1, 9999);
      run("vlan1", 16'h0123, 46, 1, 0, 0, -1, 9999);
      vt2 = 16'h0456;
      wr_reg(rx_status_pkg::OFF_VLAN2_TAG, 32'(vt2));
      run("vlan2", 16'h0456, 46, 1, 0, 0, -1, 9999);
      run("pad", 40, 46, 1, 0, 0, -1, 9999);
      run("short", 47, 46, 1, 0, 0, -1, 9999);
      run("fcs", 46, 46, 1, 0, 1, -1, 9999);
      run("dribble", 46, 46, 1, 1, 0, -1, 9999);
      run("mii error", 46, 46, 1, 0, 0, 20, 9999);
      run("late col", 46, 62, 1, 0, 0, -1, 66);
      run("type", 16'h0800, 46, 1, 0, 0, -1, 9999);
      fd = 0;
      wr_reg(rx_status_pkg::OFF_MAC_CTRL, 32'(fd));
      run("half duplex", 16'h8808, 46, 2, 0, 0, -1, 9999);
      // Frame while disarmed: done and status stay as they were
      repeat (64) fq.push_back(8'($urandom));
      u_mii_phy_model.send(fq, 1'b0, -1, 9999);
      check("disarmed done", {31'h0, transfer_done_flag}, 32'h0);
      rd_reg(rx_status_pkg::OFF_RX_STATUS, rd_val);
      check("disarmed status", rd_val, last_exp);
      $display("test disarmed done");
      run("long", 46, 1501, 1, 0, 1, -1, 9999);
      summarize();
   end
endmodule // testbench

// ### logic/fcs_crc32.sv
/*
 Byte-wise Ethernet CRC-32 accumulator, LSB first.
 Assumes init and en are never high together with conflicting intent;
 init wins. Running over data plus FCS leaves the fixed residue.
*/
`timescale 1ns/100ps
module fcs_crc32 (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Byte stream
   input wire logic init,
   input wire logic en,
   input wire logic [7:0] data,
   // Running value
   output logic [31:0] crc
);
   logic [31:0] crc_reg;
   logic [31:0] crc_next;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int b = 0; b < 8; b++) begin
         if (r[0] ^ d[b]) begin
            r = (r >> 1) ^ rx_status_pkg::CRC_POLY_REFL;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   always_comb begin
      crc_next = crc_reg;
      if (init) begin
         crc_next = rx_status_pkg::CRC_INIT;
      end else if (en) begin
         crc_next = crc_byte(crc_reg, data);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_reg <= rx_status_pkg::CRC_INIT;
      end else begin
         crc_reg <= crc_next;
      end
   end

   assign crc = crc_reg;
endmodule // fcs_crc32

// ### logic/pin_sync.sv
/*
 Two-flop synchroniser for a group of level inputs.
 Assumes inputs are asynchronous to clk; only the second stage is visible.
*/
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= async_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign sync_out = sync_reg;
endmodule // pin_sync

// ### logic/rx_frame_status_classifier.sv
/*
 Receive frame status classifier: samples MII receive pins, assembles bytes,
 classifies the frame and flags errors, then publishes status bits 26..17 as
 one word and raises the done flag.
 Assumes the MII receive clock is slow against mclk (10 Mb/s MII), since the
 pins are oversampled after synchronisation. Software reads the status only
 after done.
// Summary of operation
// - Unsupported-control set for unknown opcode or control frame length not 64 bytes.
// - Unsupported-control flag is only set in full duplex.
// - Control set with unsupported clear means a pause frame arrived.
// - Control-frame flag set for MAC control frames, full duplex only.
// - Length error when fewer data bytes arrive than length field declares.
// - Surplus data bytes are padding; no length error.
// - Length error only meaningful for 802.3 frames, frame type zero.
// - Length and FCS error not applied to frames above maximum Ethernet size.
// - Second VLAN match when bytes thirteen and fourteen are nonzero and equal tag two.
// - First VLAN match when bytes thirteen and fourteen are nonzero and equal tag one.
// - FCS error set when frame check sequence is wrong, clear otherwise.
// - Dribble flag set when bit count is not a multiple of eight.
// - Media-interface error flag set when MII signals error during reception.
// - Frame type clear for length frames, set when length/type exceeds 1500.
// - Frame type invalid for runts under 14 bytes.
// - Late collision flag set for collision after first 64 bytes.
*/
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
module rx_frame_status_classifier (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // MII receive pins
   input wire logic mii_rx_clk,
   input wire logic mii_rx_dv,
   input wire logic mii_rx_er,
   input wire logic [3:0] mii_rxd,
   input wire logic mii_col,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Status
   output logic transfer_done_flag
);
   typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_DATA, ST_SKIP} rx_state_t;

   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_n;
   logic [7:0] pins;
   logic rxc_prev_reg;
   logic rxc_rise;
   logic dv;
   logic er;
   logic col;
   logic [3:0] nib;

   rx_state_t state_reg, state_next;
   logic half_reg, half_next;
   logic [3:0] low_reg, low_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [15:0] lt_reg, lt_next;
   logic [15:0] op_reg, op_next;
   logic me_reg, me_next;
   logic lc_reg, lc_next;
   logic [31:0] status_reg, status_next;
   logic done_reg, done_next;
   logic en_reg, en_next;
   logic pub_reg, pub_next;
   logic fdx_reg, fdx_next;
   logic [15:0] vlan1_reg, vlan1_next;
   logic [15:0] vlan2_reg, vlan2_next;
   logic [31:0] rdata_reg, rdata_next;

   logic crc_init;
   logic crc_en;
   logic [7:0] byte_val;
   logic [31:0] crc_val;

   logic hdr_ok, data_ok;
   logic v1, v2, ft, too_long, ctrl, uc, le, fcs_bad;
   logic [15:0] max_sz, data_len;
   logic frame_end;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   pin_sync #(.WIDTH(8)) u_pin_sync (
      .clk(mclk),
      .rst_n(rst_n),
      .async_in({mii_rx_clk, mii_col, mii_rx_er, mii_rx_dv, mii_rxd}),
      .sync_out(pins)
   );

   assign nib = pins[3:0];
   assign dv = pins[4];
   assign er = pins[5];
   assign col = pins[6];
   assign rxc_rise = pins[7] & ~rxc_prev_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxc_prev_reg <= 1'b0;
      end else begin
         rxc_prev_reg <= pins[7];
      end
   end

   assign byte_val = {nib, low_reg};
   assign crc_init = (state_reg == ST_PRE);
   assign crc_en = (state_reg == ST_DATA) && rxc_rise && dv && half_reg;

   fcs_crc32 u_fcs_crc32 (
      .clk(mclk),
      .rst_n(rst_n),
      .init(crc_init),
      .en(crc_en),
      .data(byte_val),
      .crc(crc_val)
   );

   // Classification of the finished frame
   always_comb begin
      hdr_ok = (cnt_reg >= rx_status_pkg::HDR_BYTES);
      data_ok = (cnt_reg >= rx_status_pkg::OVERHEAD_BYTES);
      data_len = data_ok ? (cnt_reg - rx_status_pkg::OVERHEAD_BYTES) : 16'h0000;
      v2 = hdr_ok && (lt_reg != 16'h0000) && (lt_reg == vlan2_reg);
      v1 = hdr_ok && (lt_reg != 16'h0000) && (lt_reg == vlan1_reg);
      max_sz = v2 ? rx_status_pkg::MAX_ETH_VLAN2 :
               (v1 ? rx_status_pkg::MAX_ETH_VLAN1 : rx_status_pkg::MAX_ETH_NORMAL);
      too_long = (data_len > max_sz);
      // Frame type is forced to zero on runts that lack the length/type field
      ft = hdr_ok && (lt_reg > rx_status_pkg::MAX_ETH_NORMAL);
      ctrl = fdx_reg && hdr_ok && (lt_reg == rx_status_pkg::MAC_CTRL_TYPE);
      uc = ctrl && ((op_reg != rx_status_pkg::PAUSE_OPCODE) ||
                    (cnt_reg != rx_status_pkg::MIN_FRAME_SIZE));
      le = !ft && !too_long && data_ok && (data_len < lt_reg);
      fcs_bad = !too_long && (crc_val != rx_status_pkg::CRC_RESIDUE);
   end

   // Receive sequencing
   always_comb begin
      state_next = state_reg;
      half_next = half_reg;
      low_next = low_reg;
      cnt_next = cnt_reg;
      lt_next = lt_reg;
      op_next = op_reg;
      me_next = me_reg;
      lc_next = lc_reg;
      frame_end = 1'b0;
      if (rxc_rise) begin
         unique case (state_reg)
            ST_IDLE: begin
               // A frame already in progress when not armed is dropped whole
               if (dv) begin
                  state_next = en_reg ? ST_PRE : ST_SKIP;
                  me_next = er;
                  lc_next = 1'b0;
               end
            end
            ST_PRE: begin
               if (!dv) begin
                  state_next = ST_IDLE;
               end else if (nib == rx_status_pkg::SFD_NIBBLE) begin
                  state_next = ST_DATA;
                  half_next = 1'b0;
                  cnt_next = 16'h0000;
                  lt_next = 16'h0000;
                  op_next = 16'h0000;
               end
               if (dv && er) begin
                  me_next = 1'b1;
               end
            end
            ST_DATA: begin
               if (!dv) begin
                  frame_end = 1'b1;
                  state_next = ST_IDLE;
               end else begin
                  if (er) begin
                     me_next = 1'b1;
                  end
                  if (col && (cnt_reg >= rx_status_pkg::LATE_COL_BYTES)) begin
                     lc_next = 1'b1;
                  end
                  if (!half_reg) begin
                     low_next = nib;
                     half_next = 1'b1;
                  end else begin
                     half_next = 1'b0;
                     if (cnt_reg != rx_status_pkg::BYTE_CNT_MAX) begin
                        cnt_next = cnt_reg + 16'h0001;
                     end
                     if (cnt_reg == rx_status_pkg::IDX_LT_HI) begin
                        lt_next = {byte_val, lt_reg[7:0]};
                     end
                     if (cnt_reg == rx_status_pkg::IDX_LT_LO) begin
                        lt_next = {lt_reg[15:8], byte_val};
                     end
                     if (cnt_reg == rx_status_pkg::IDX_OP_HI) begin
                        op_next = {byte_val, op_reg[7:0]};
                     end
                     if (cnt_reg == rx_status_pkg::IDX_OP_LO) begin
                        op_next = {op_reg[15:8], byte_val};
                     end
                  end
               end
            end
            ST_SKIP: begin
               if (!dv) begin
                  state_next = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         half_reg <= 1'b0;
         low_reg <= 4'h0;
         cnt_reg <= 16'h0000;
         lt_reg <= 16'h0000;
         op_reg <= 16'h0000;
         me_reg <= 1'b0;
         lc_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         half_reg <= half_next;
         low_reg <= low_next;
         cnt_reg <= cnt_next;
         lt_reg <= lt_next;
         op_reg <= op_next;
         me_reg <= me_next;
         lc_reg <= lc_next;
      end
   end

   // Status word, transfer control and register port
   always_comb begin
      status_next = status_reg;
      pub_next = 1'b0;
      done_next = done_reg;
      en_next = en_reg;
      fdx_next = fdx_reg;
      vlan1_next = vlan1_reg;
      vlan2_next = vlan2_reg;
      rdata_next = 32'h0000_0000;
      if (wr) begin
         unique case (addr)
            rx_status_pkg::OFF_MAC_CTRL: fdx_next = wdata[rx_status_pkg::BIT_FULL_DUPLEX];
            rx_status_pkg::OFF_VLAN1_TAG: vlan1_next = wdata[15:0];
            rx_status_pkg::OFF_VLAN2_TAG: vlan2_next = wdata[15:0];
            rx_status_pkg::OFF_RX_XFER: begin
               if (wdata[rx_status_pkg::BIT_XFER_EN]) begin
                  en_next = 1'b1;
               end
               if (wdata[rx_status_pkg::BIT_XFER_DONE]) begin
                  done_next = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // Whole word is replaced in one edge; done follows one edge later
      if (frame_end) begin
         status_next = rx_status_pkg::RST_RX_STATUS;
         status_next[rx_status_pkg::BIT_UNSUP_CTRL] = uc;
         status_next[rx_status_pkg::BIT_CTRL_FRAME] = ctrl;
         status_next[rx_status_pkg::BIT_LEN_ERR] = le;
         status_next[rx_status_pkg::BIT_VLAN2] = v2;
         status_next[rx_status_pkg::BIT_VLAN1] = v1;
         status_next[rx_status_pkg::BIT_FCS_ERR] = fcs_bad;
         status_next[rx_status_pkg::BIT_DRIBBLE] = half_reg;
         status_next[rx_status_pkg::BIT_MEDIA_ERR] = me_reg;
         status_next[rx_status_pkg::BIT_FRAME_TYPE] = ft;
         status_next[rx_status_pkg::BIT_LATE_COL] = lc_reg;
         pub_next = 1'b1;
         en_next = 1'b0;
      end
      // Set wins over a same-cycle clear
      if (pub_reg) begin
         done_next = 1'b1;
      end
      if (rd) begin
         unique case (addr)
            rx_status_pkg::OFF_RX_STATUS: rdata_next = status_reg;
            rx_status_pkg::OFF_MAC_CTRL: rdata_next = {31'h0, fdx_reg};
            rx_status_pkg::OFF_VLAN1_TAG: rdata_next = {16'h0000, vlan1_reg};
            rx_status_pkg::OFF_VLAN2_TAG: rdata_next = {16'h0000, vlan2_reg};
            rx_status_pkg::OFF_RX_XFER: rdata_next = {30'h0, done_reg, en_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= rx_status_pkg::RST_RX_STATUS;
         pub_reg <= 1'b0;
         done_reg <= 1'b0;
         en_reg <= 1'b0;
         fdx_reg <= 1'b0;
         vlan1_reg <= rx_status_pkg::RST_VLAN_TAG;
         vlan2_reg <= rx_status_pkg::RST_VLAN_TAG;
         rdata_reg <= 32'h0000_0000;
      end else begin
         status_reg <= status_next;
         pub_reg <= pub_next;
         done_reg <= done_next;
         en_reg <= en_next;
         fdx_reg <= fdx_next;
         vlan1_reg <= vlan1_next;
         vlan2_reg <= vlan2_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign transfer_done_flag = done_reg;
endmodule // rx_frame_status_classifier

// ### logic/rx_status_pkg.sv
/*
 Shared constants for the receive frame status classifier: register map,
 status word field positions, Ethernet size limits and MII framing values.
 Assumes a 32-bit register port and byte-wide frame processing.
*/
package rx_status_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_RX_STATUS = 8'h00;
   localparam logic [7:0] OFF_MAC_CTRL = 8'h04;
   localparam logic [7:0] OFF_VLAN1_TAG = 8'h08;
   localparam logic [7:0] OFF_VLAN2_TAG = 8'h0C;
   localparam logic [7:0] OFF_RX_XFER = 8'h10;

   // Status word bit positions
   localparam int BIT_UNSUP_CTRL = 26;
   localparam int BIT_CTRL_FRAME = 25;
   localparam int BIT_LEN_ERR = 24;
   localparam int BIT_VLAN2 = 23;
   localparam int BIT_VLAN1 = 22;
   localparam int BIT_FCS_ERR = 21;
   localparam int BIT_DRIBBLE = 20;
   localparam int BIT_MEDIA_ERR = 19;
   localparam int BIT_FRAME_TYPE = 18;
   localparam int BIT_LATE_COL = 17;

   // Control and transfer register bit positions
   localparam int BIT_FULL_DUPLEX = 0;
   localparam int BIT_XFER_EN = 0;
   localparam int BIT_XFER_DONE = 1;

   // Reset values
   localparam logic [31:0] RST_RX_STATUS = 32'h0000_0000;
   localparam logic [15:0] RST_VLAN_TAG = 16'h0000;

   // Ethernet sizes in bytes
   localparam logic [15:0] MAX_ETH_NORMAL = 16'h05DC;
   localparam logic [15:0] MAX_ETH_VLAN1 = 16'h05EE;
   localparam logic [15:0] MAX_ETH_VLAN2 = 16'h0602;
   localparam logic [15:0] MIN_FRAME_SIZE = 16'h0040;
   localparam logic [15:0] HDR_BYTES = 16'h000E;
   localparam logic [15:0] OVERHEAD_BYTES = 16'h0012;
   localparam logic [15:0] LATE_COL_BYTES = 16'h0040;
   localparam logic [15:0] BYTE_CNT_MAX = 16'hFFFF;

   // Header byte indices
   localparam logic [15:0] IDX_LT_HI = 16'h000C;
   localparam logic [15:0] IDX_LT_LO = 16'h000D;
   localparam logic [15:0] IDX_OP_HI = 16'h000E;
   localparam logic [15:0] IDX_OP_LO = 16'h000F;

   // Frame codes
   localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
   localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
   localparam logic [3:0] SFD_NIBBLE = 4'hD;
   localparam logic [3:0] PRE_NIBBLE = 4'h5;

   // FCS
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY_REFL = 32'hEDB8_8320;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
endpackage
